// File: hw/dcs_dma_ctrl.sv
// Two-channel DMA control, status and mode logic with its transfer sequencer.
//
// Behaviour
// - Channel runs only with own and main enable.
// - Count reaching zero clears channel enable.
// - Disabled channel with interrupt enable requests interrupt.
// - Enable bit written only with mask zero.
// - Writing zero pauses; writing one also sets main.
// - Write-mask bits always read as one.
// - Non-maskable interrupt clears main enable.
// - Rewriting enable one restarts after non-maskable interrupt.
// - Main enable ignores direct software writes.
// - Reset clears enables and interrupt enables.
// - Channel 0 destination mode: inc, dec, fixed, I/O.
// - Channel 0 source mode uses same encoding.
// - I/O to I/O is never run.
// - Memory mode selects burst or cycle steal.
// - I/O transfers paced by request; memory mode ignored.
// - Memory wait field stretches memory cycles.
// - I/O wait field stretches I/O cycles.
// - Sense bits pick level or edge requests.
// - Each byte: source read, then destination write.
// - Channel 1 mode field sets direction, step.
// - Channel 1 memory steps up or down; I/O fixed.
// - Byte count drops by one per byte.
// - Address upper bits select the pacing request.
`timescale 1ns/1ps
module dcs_dma_ctrl #(
  parameter int CW = 16,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // CPU I/O register access
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // Interrupts
  input wire logic i_nmi_n,
  output logic o_irq,
  // Request sources and their selection
  input wire logic i_ext_req_n,
  input wire logic i_ser0_tx_req,
  input wire logic i_ser1_tx_req,
  input wire logic [1:0] i_ch0_req_sel,
  input wire logic [1:0] i_ch1_req_sel,
  // Byte count loading
  input wire logic [1:0] i_cnt_load,
  input wire logic [CW-1:0] i_cnt_value,
  // System bus
  output dcs_pkg::dcs_bus_t o_bus,
  input wire logic [7:0] i_bus_rdata,
  // Status and wait settings
  output logic [1:0] o_chan_live,
  output logic [1:0] o_mem_waits,
  output logic [1:0] o_io_waits
);
  typedef struct packed {
    dcs_pkg::dcs_state_t st;
    logic [1:0] wcnt;
    logic chan;
    logic primed;
    logic [1:0] de;
    logic [1:0] die;
    logic main_en;
    logic [7:0] mode;
    logic [7:0] wctl;
    logic [1:0][CW-1:0] cnt;
    logic [1:0] pend;
    logic [1:0] req_prev;
    logic [1:0] sync_req;
    logic [1:0] sync_nmi;
    logic nmi_prev;
    logic [7:0] rdata;
    logic irq;
    logic [1:0] live;
    dcs_pkg::dcs_bus_t bus;
  } dcs_st_t;

  // The non-maskable pin idles high, so its synchroniser resets high.
  localparam dcs_st_t ST_RST = '{
    st: dcs_pkg::ST_IDLE,
    wctl: dcs_pkg::DCS_WAIT_RST,
    mode: dcs_pkg::DCS_MODE_RST,
    sync_nmi: 2'h3,
    nmi_prev: 1'h1,
    default: '0
  };

  dcs_st_t r;
  dcs_st_t n;
  logic [1:0] raw_req;
  logic [1:0] req_ok;
  logic [1:0] sense_edge;
  logic [1:0] run;
  logic [1:0][1:0] src_mode;
  logic [1:0][1:0] dst_mode;
  logic ch0_paced;
  logic ch0_both_io;
  logic nmi_fall;
  logic [7:0] status_rd;
  logic fifo_in_rdy;
  logic fifo_out_v;
  logic [7:0] fifo_out_d;
  logic push_v;
  logic pop;

  // Wait states for one access, chosen by whether it is memory or I/O.
  function automatic logic [1:0] waits_of(input logic [1:0] am, input logic [7:0] wctl);
    waits_of = (am == dcs_pkg::DCS_AM_IO) ? wctl[dcs_pkg::DCS_WC_IWI_LO +: 2]
                                          : wctl[dcs_pkg::DCS_WC_MWI_LO +: 2];
  endfunction

  function automatic logic pick_req(input logic [1:0] sel, input logic pin,
                                    input logic s0, input logic s1);
    pick_req = (sel == dcs_pkg::DCS_RQ_PIN) ? pin :
               (sel == dcs_pkg::DCS_RQ_SER0) ? s0 :
               (sel == dcs_pkg::DCS_RQ_SER1) ? s1 : 1'b0;
  endfunction

  // Per-channel request sensing and address modes.
  for (genvar c = 0; c < 2; c++) begin : g_chan
    if (c == 0) begin : g_c0
      assign raw_req[c] = pick_req(i_ch0_req_sel, r.sync_req[1], i_ser0_tx_req, i_ser1_tx_req);
      assign sense_edge[c] = r.wctl[dcs_pkg::DCS_WC_SENSE_CH0];
      assign dst_mode[c] = r.mode[dcs_pkg::DCS_MD_DST_LO +: 2];
      assign src_mode[c] = r.mode[dcs_pkg::DCS_MD_SRC_LO +: 2];
    end else begin : g_c1
      logic [1:0] mem_am;
      assign raw_req[c] = pick_req(i_ch1_req_sel, r.sync_req[1], i_ser0_tx_req, i_ser1_tx_req);
      assign sense_edge[c] = r.wctl[dcs_pkg::DCS_WC_SENSE_CH1];
      assign mem_am = r.wctl[dcs_pkg::DCS_WC_DEC] ? dcs_pkg::DCS_AM_DEC : dcs_pkg::DCS_AM_INC;
      assign src_mode[c] = r.wctl[dcs_pkg::DCS_WC_DIR] ? dcs_pkg::DCS_AM_IO : mem_am;
      assign dst_mode[c] = r.wctl[dcs_pkg::DCS_WC_DIR] ? mem_am : dcs_pkg::DCS_AM_IO;
    end
    assign req_ok[c] = sense_edge[c] ? r.pend[c] : raw_req[c];
    // Status readback, write-mask bits forced high.
    assign status_rd[dcs_pkg::DCS_ST_CH0_EN + c] = r.de[c];
    assign status_rd[dcs_pkg::DCS_ST_WE0 + c] = 1'b1;
    assign status_rd[dcs_pkg::DCS_ST_CH0_IRQ_EN + c] = r.die[c];
  end
  assign status_rd[dcs_pkg::DCS_ST_MAIN_EN] = r.main_en;
  assign status_rd[dcs_pkg::DCS_ST_MAIN_EN + 1] = 1'b0;

  // Channel qualification; channel 0 memory-to-memory needs no request.
  assign ch0_both_io = (src_mode[0] == dcs_pkg::DCS_AM_IO) && (dst_mode[0] == dcs_pkg::DCS_AM_IO);
  assign ch0_paced = (src_mode[0] == dcs_pkg::DCS_AM_IO) || (dst_mode[0] == dcs_pkg::DCS_AM_IO);
  assign run[0] = r.de[0] & r.main_en & ~ch0_both_io & (~ch0_paced | req_ok[0]);
  assign run[1] = r.de[1] & r.main_en & req_ok[1];

  // Only the second synchroniser stage and its delayed copy see the edge.
  assign nmi_fall = r.nmi_prev & ~r.sync_nmi[1];

  // FIFO handshakes between the read and write halves.
  assign push_v = (r.st == dcs_pkg::ST_READ) && (r.wcnt == '0);
  assign pop = (r.st == dcs_pkg::ST_WRITE) && (r.wcnt == '0) && r.primed && fifo_out_v;

  dcs_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push_v),
    .o_in_ready(fifo_in_rdy),
    .i_in_data(i_bus_rdata),
    .o_out_valid(fifo_out_v),
    .i_out_ready(pop),
    .o_out_data(fifo_out_d)
  );

  // Next-state logic; later blocks override earlier ones on purpose.
  always_comb begin
    n = r;
    n.sync_req = {r.sync_req[0], ~i_ext_req_n};
    n.sync_nmi = {r.sync_nmi[0], i_nmi_n};
    n.nmi_prev = r.sync_nmi[1];
    n.bus.src_inc = 1'b0;
    n.bus.src_dec = 1'b0;
    n.bus.dst_inc = 1'b0;
    n.bus.dst_dec = 1'b0;
    unique case (r.st)
      dcs_pkg::ST_IDLE: begin
        if (run[0] || run[1]) begin
          n.st = dcs_pkg::ST_READ;
          n.chan = ~run[0];
          n.wcnt = waits_of(src_mode[~run[0]], r.wctl);
          n.pend[~run[0]] = 1'b0;
        end
      end
      dcs_pkg::ST_READ: begin
        if (r.wcnt != '0) begin
          n.wcnt = r.wcnt - 1'b1;
        end else if (fifo_in_rdy) begin
          n.st = dcs_pkg::ST_WRITE;
          n.primed = 1'b0;
          n.wcnt = waits_of(dst_mode[r.chan], r.wctl);
          n.bus.src_inc = (src_mode[r.chan] == dcs_pkg::DCS_AM_INC);
          n.bus.src_dec = (src_mode[r.chan] == dcs_pkg::DCS_AM_DEC);
        end
      end
      dcs_pkg::ST_WRITE: begin
        n.primed = 1'b1;
        n.bus.wdata = fifo_out_d;
        if (r.wcnt != '0) begin
          n.wcnt = r.wcnt - 1'b1;
        end else if (pop) begin
          n.bus.dst_inc = (dst_mode[r.chan] == dcs_pkg::DCS_AM_INC);
          n.bus.dst_dec = (dst_mode[r.chan] == dcs_pkg::DCS_AM_DEC);
          n.cnt[r.chan] = r.cnt[r.chan] - 1'b1;
          n.st = dcs_pkg::ST_IDLE;
          if (r.cnt[r.chan] == CW'(1)) begin
            n.de[r.chan] = 1'b0;
          end else if (!r.chan && !ch0_paced && run[0]) begin
            if (r.mode[dcs_pkg::DCS_MD_TIMING]) begin
              n.st = dcs_pkg::ST_READ;
              n.wcnt = waits_of(src_mode[0], r.wctl);
            end else begin
              n.st = dcs_pkg::ST_GAP;
            end
          end
        end
      end
      dcs_pkg::ST_GAP: begin
        n.st = dcs_pkg::ST_IDLE;
      end
      default: begin
        n.st = dcs_pkg::ST_IDLE;
      end
    endcase
    n.bus.rd = (n.st == dcs_pkg::ST_READ);
    n.bus.wr = (n.st == dcs_pkg::ST_WRITE);
    n.bus.req = n.bus.rd | n.bus.wr;
    n.bus.chan = n.chan;
    n.bus.io = n.bus.rd ? (src_mode[n.chan] == dcs_pkg::DCS_AM_IO) :
               n.bus.wr ? (dst_mode[n.chan] == dcs_pkg::DCS_AM_IO) : 1'b0;
    // Edge latches: a new edge wins over the clear taken at start.
    for (int c = 0; c < 2; c++) begin
      n.req_prev[c] = raw_req[c];
      if (raw_req[c] && !r.req_prev[c]) begin
        n.pend[c] = 1'b1;
      end
      if (i_cnt_load[c]) begin
        n.cnt[c] = i_cnt_value;
      end
    end
    // Software writes; a write overrides a same-cycle termination clear.
    if (i_io_wr) begin
      unique case (i_io_addr)
        dcs_pkg::DCS_ADDR_STATUS: begin
          for (int c = 0; c < 2; c++) begin
            if (!i_io_wdata[dcs_pkg::DCS_ST_WE0 + c]) begin
              n.de[c] = i_io_wdata[dcs_pkg::DCS_ST_CH0_EN + c];
              if (i_io_wdata[dcs_pkg::DCS_ST_CH0_EN + c]) begin
                n.main_en = 1'b1;
              end
            end
            n.die[c] = i_io_wdata[dcs_pkg::DCS_ST_CH0_IRQ_EN + c];
          end
        end
        dcs_pkg::DCS_ADDR_MODE: n.mode = i_io_wdata & dcs_pkg::DCS_MODE_MASK;
        dcs_pkg::DCS_ADDR_WAIT: n.wctl = i_io_wdata;
        default: n.mode = r.mode;
      endcase
    end
    if (nmi_fall) begin
      n.main_en = 1'b0;
    end
    if (i_io_rd) begin
      n.rdata = (i_io_addr == dcs_pkg::DCS_ADDR_STATUS) ? status_rd :
                (i_io_addr == dcs_pkg::DCS_ADDR_MODE) ? r.mode :
                (i_io_addr == dcs_pkg::DCS_ADDR_WAIT) ? r.wctl : 8'h00;
    end
    n.irq = |(~r.de & r.die);
    n.live = r.de & {2{r.main_en}};
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register.
  assign o_io_rdata = r.rdata;
  assign o_irq = r.irq;
  assign o_bus = r.bus;
  assign o_chan_live = r.live;
  assign o_mem_waits = r.wctl[dcs_pkg::DCS_WC_MWI_LO +: 2];
  assign o_io_waits = r.wctl[dcs_pkg::DCS_WC_IWI_LO +: 2];

  // Checks on the sequencer and the register side effects.
  logic wr_st;
  assign wr_st = i_io_wr && (i_io_addr == dcs_pkg::DCS_ADDR_STATUS);

  sequence s_read_done;
    (r.st == dcs_pkg::ST_READ) && (r.wcnt == '0) && fifo_in_rdy;
  endsequence
  sequence s_steal_end;
    pop && !r.chan && !ch0_paced && run[0] && !r.mode[dcs_pkg::DCS_MD_TIMING]
      && (r.cnt[0] != CW'(1));
  endsequence

  AST_START_NEEDS_ENABLES: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (r.st == dcs_pkg::ST_IDLE) ##1 (r.st == dcs_pkg::ST_READ)
    |-> (r.chan ? $past(r.de[1]) : $past(r.de[0])) && $past(r.main_en))
    else $error("Transfer started without both enables.");
  AST_TERM_CLEARS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    pop && (r.cnt[r.chan] == CW'(1)) && !wr_st |=> !r.de[$past(r.chan)])
    else $error("Enable not cleared at terminal count.");
  AST_IRQ_LEVEL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    |(~r.de & r.die) |=> o_irq)
    else $error("Interrupt request missing.");
  AST_MASKED_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wr_st && i_io_wdata[dcs_pkg::DCS_ST_WE0 + 1] && !pop |=> r.de[1] == $past(r.de[1]))
    else $error("Masked write changed channel 1 enable.");
  AST_SET_MAIN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wr_st && !i_io_wdata[dcs_pkg::DCS_ST_WE0] && i_io_wdata[dcs_pkg::DCS_ST_CH0_EN] && !nmi_fall
    |=> r.main_en && r.de[0])
    else $error("Enable write did not set main enable.");
  AST_MASK_READS_ONE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_io_rd && (i_io_addr == dcs_pkg::DCS_ADDR_STATUS) |=> o_io_rdata[5:4] == 2'h3)
    else $error("Write-mask bits did not read as one.");
  AST_NMI_CLEARS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(r.sync_nmi[1]) |=> !r.main_en)
    else $error("Main enable survived non-maskable interrupt.");
  AST_NO_DIRECT_MAIN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !r.main_en && !(wr_st && ((~i_io_wdata[5:4]) & i_io_wdata[7:6]) != 2'h0) |=> !r.main_en)
    else $error("Main enable set without an enable write.");
  AST_READ_THEN_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_read_done |=> (r.st == dcs_pkg::ST_WRITE) && o_bus.wr && !o_bus.rd)
    else $error("Read not followed by write.");
  AST_CYCLE_STEAL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_steal_end |=> (r.st == dcs_pkg::ST_GAP) && !o_bus.req ##1 (r.st == dcs_pkg::ST_IDLE))
    else $error("Cycle steal gap not given to the CPU.");
endmodule

// File: hw/dcs_pkg.sv
// Shared constants and types for the DMA control, status and mode block.
package dcs_pkg;

  // Register I/O addresses.
  localparam logic [7:0] DCS_ADDR_STATUS = 8'h30;
  localparam logic [7:0] DCS_ADDR_MODE = 8'h31;
  localparam logic [7:0] DCS_ADDR_WAIT = 8'h32;

  // Status register bit positions; channel 1 bits sit one above channel 0.
  localparam int DCS_ST_CH0_EN = 6;
  localparam int DCS_ST_WE0 = 4;
  localparam int DCS_ST_CH0_IRQ_EN = 2;
  localparam int DCS_ST_MAIN_EN = 0;
  localparam logic [7:0] DCS_ST_WE_ONES = 8'h30;

  // Channel 0 mode register fields.
  localparam int DCS_MD_DST_LO = 4;
  localparam int DCS_MD_SRC_LO = 2;
  localparam int DCS_MD_TIMING = 1;
  localparam logic [7:0] DCS_MODE_MASK = 8'h3e;
  localparam logic [7:0] DCS_MODE_RST = 8'h00;

  // Wait and sense control register fields.
  localparam int DCS_WC_MWI_LO = 6;
  localparam int DCS_WC_IWI_LO = 4;
  localparam int DCS_WC_SENSE_CH0 = 3;
  localparam int DCS_WC_SENSE_CH1 = 2;
  localparam int DCS_WC_DIR = 1;
  localparam int DCS_WC_DEC = 0;
  localparam logic [7:0] DCS_WAIT_RST = 8'hf0;

  // Address mode encoding shared by source and destination fields.
  localparam logic [1:0] DCS_AM_INC = 2'h0;
  localparam logic [1:0] DCS_AM_DEC = 2'h1;
  localparam logic [1:0] DCS_AM_FIX = 2'h2;
  localparam logic [1:0] DCS_AM_IO = 2'h3;

  // Request source selection taken from the address register upper bits.
  localparam logic [1:0] DCS_RQ_PIN = 2'h0;
  localparam logic [1:0] DCS_RQ_SER0 = 2'h1;
  localparam logic [1:0] DCS_RQ_SER1 = 2'h2;

  // Transfer sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_WRITE = 4'h4,
    ST_GAP = 4'h8
  } dcs_state_t;

  // System bus master signals.
  typedef struct packed {
    logic req;
    logic rd;
    logic wr;
    logic io;
    logic chan;
    logic src_inc;
    logic src_dec;
    logic dst_inc;
    logic dst_dec;
    logic [7:0] wdata;
  } dcs_bus_t;

endpackage

// File: hw/dcs_fifo.sv
// Small flip-flop FIFO between the read and write halves of a transfer.
`timescale 1ns/1ps
module dcs_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CNW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CNW-1:0] cnt;
  } dcs_fifo_st_t;

  dcs_fifo_st_t r;
  dcs_fifo_st_t n;
  logic push;
  logic pop;

  // Handshakes; full and empty come straight from the occupancy count.
  assign o_in_ready = (r.cnt != CNW'(D));
  assign o_out_valid = (r.cnt != '0);
  assign o_out_data = r.mem[r.rp];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Pointers wrap explicitly so a depth that is not a power of two works.
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = i_in_data;
      n.wp = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + CNW'(push) - CNW'(pop);
  end

  // State register.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// File: bench/dcs_bus_model.sv
// Behavioural memory and I/O peripheral model on the DMA system bus.
`timescale 1ns/1ps
module dcs_bus_model (
  // Clock
  input wire logic i_core_clk,
  // Bus driven by the block
  input dcs_pkg::dcs_bus_t i_bus,
  // Data returned to the block
  output logic [7:0] o_rdata
);
  int n_rd = 0;
  int n_iord = 0;
  int n_wr = 0;
  int n_req = 0;
  int n_inc = 0;
  int n_dec = 0;
  int n_ovl = 0;
  int n_ch1 = 0;
  int n_rdcyc = 0;
  logic [7:0] cur = 8'h3c;
  logic [7:0] last_wdata = 8'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic req_q = 1'b0;

  // A released data bus shows the inverse byte, so a late sample cannot match by luck.
  assign o_rdata = i_bus.rd ? cur : ~cur;

  // Count bus events; each read serves a fresh byte value.
  always @(posedge i_core_clk) begin
    rd_q <= i_bus.rd;
    wr_q <= i_bus.wr;
    req_q <= i_bus.req;
    if (i_bus.rd && !rd_q) begin
      n_rd <= n_rd + 1;
      n_iord <= n_iord + int'(i_bus.io);
      n_ch1 <= n_ch1 + int'(i_bus.chan);
    end
    // Read cycles show the wait states stretching each source access.
    n_rdcyc <= n_rdcyc + int'(i_bus.rd);
    if (!i_bus.rd && rd_q) begin
      cur <= cur + 8'h11;
    end
    if (i_bus.wr) begin
      last_wdata <= i_bus.wdata;
    end
    if (!i_bus.wr && wr_q) begin
      n_wr <= n_wr + 1;
    end
    if (i_bus.req && !req_q) begin
      n_req <= n_req + 1;
    end
    n_inc <= n_inc + int'(i_bus.src_inc) + int'(i_bus.dst_inc);
    n_dec <= n_dec + int'(i_bus.src_dec) + int'(i_bus.dst_dec);
    if (i_bus.rd && i_bus.wr) begin
      n_ovl <= n_ovl + 1;
    end
  end
endmodule

// File: bench/dcs_dma_ctrl_test.sv
// Self-checking bench for the DMA control, status and mode block.
`timescale 1ns/1ps
module dcs_dma_ctrl_test;
  logic i_core_clk, i_rst_n, i_io_wr, i_io_rd, i_nmi_n, i_ext_req_n, o_irq;
  logic i_ser0_tx_req, i_ser1_tx_req;
  logic [7:0] i_io_addr, i_io_wdata, o_io_rdata, i_bus_rdata, rd_val;
  logic [1:0] i_ch0_req_sel, i_ch1_req_sel, i_cnt_load, o_chan_live, o_mem_waits, o_io_waits;
  logic [15:0] i_cnt_value;
  dcs_pkg::dcs_bus_t o_bus;
  int miscompares = 0;
  int checks_done = 0;

  dcs_dma_ctrl #(.CW(16), .FIFO_DEPTH(4)) i_dut (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
    .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_nmi_n(i_nmi_n), .o_irq(o_irq),
    .i_ext_req_n(i_ext_req_n), .i_ser0_tx_req(i_ser0_tx_req),
    .i_ser1_tx_req(i_ser1_tx_req), .i_ch0_req_sel(i_ch0_req_sel),
    .i_ch1_req_sel(i_ch1_req_sel), .i_cnt_load(i_cnt_load), .i_cnt_value(i_cnt_value),
    .o_bus(o_bus), .i_bus_rdata(i_bus_rdata), .o_chan_live(o_chan_live),
    .o_mem_waits(o_mem_waits), .o_io_waits(o_io_waits));

  dcs_bus_model i_partner (.i_core_clk(i_core_clk), .i_bus(o_bus), .o_rdata(i_bus_rdata));

  // Free-running 25 MHz clock.
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Register cycles: strobe for one edge, then let the registered answer settle.
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_io_addr <= a;
    i_io_wdata <= d;
    i_io_wr <= 1'b1;
    @(posedge i_core_clk);
    i_io_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_io_addr <= a;
    i_io_rd <= 1'b1;
    @(posedge i_core_clk);
    i_io_rd <= 1'b0;
    @(posedge i_core_clk);
    #1 rd_val = o_io_rdata;
    if (what != "") check(what, rd_val, exp);
  endtask

  // Poll the status register until the given enable bit has cleared, with a bound.
  task automatic wait_done(input int b);
    int k;
    for (k = 0; k < 300; k++) begin
      rd_chk("", 8'h30, 8'h00);
      if (rd_val[b] === 1'b0) break;
    end
    if (k == 300) begin
      miscompares++;
      $display("mismatch chan_done expected %h seen %h", 1'b0, 1'b1);
      end_sim();
    end
    repeat (6) @(posedge i_core_clk);
  endtask

  task automatic t_reset();
    rd_chk("status", 8'h30, 8'h30);
    rd_chk("mode", 8'h31, 8'h00);
    rd_chk("wait", 8'h32, 8'hf0);
    rd_chk("unmapped", 8'h40, 8'h00);
    check("irq", {7'h00, o_irq}, 8'h00);
    check("waits", {4'h0, o_mem_waits, o_io_waits}, 8'h0f);
    $display("test reset done");
  endtask

  task automatic t_enable();
    io_wr(8'h30, 8'hf1);
    rd_chk("masked", 8'h30, 8'h30);
    io_wr(8'h30, 8'h01);
    rd_chk("main_direct", 8'h30, 8'h30);
    io_wr(8'h30, 8'h3c);
    repeat (3) @(posedge i_core_clk);
    check("irq_set", {7'h00, o_irq}, 8'h01);
    io_wr(8'h30, 8'h9c);
    rd_chk("de1_on", 8'h30, 8'hbd);
    check("live", {6'h00, o_chan_live}, 8'h02);
    io_wr(8'h30, 8'h38);
    repeat (3) @(posedge i_core_clk);
    check("irq_clr", {7'h00, o_irq}, 8'h00);
    // A held-low pulse on the interrupt pin; the synchroniser sees one falling edge.
    @(posedge i_core_clk) i_nmi_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_nmi_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    rd_chk("nmi", 8'h30, 8'hb8);
    check("live_nmi", {6'h00, o_chan_live}, 8'h00);
    io_wr(8'h30, 8'h98);
    rd_chk("restart", 8'h30, 8'hb9);
    check("live_rs", {6'h00, o_chan_live}, 8'h02);
    io_wr(8'h30, 8'h18);
    rd_chk("pause", 8'h30, 8'h39);
    check("irq_pause", {7'h00, o_irq}, 8'h01);
    io_wr(8'h30, 8'h30);
    $display("test enable done");
  endtask

  task automatic t_regs();
    logic [7:0] wv[4] = '{8'h00, 8'h5a, 8'ha5, 8'hff};
    io_wr(8'h31, 8'hff);
    rd_chk("mode_rb", 8'h31, 8'h3e);
    foreach (wv[i]) begin
      io_wr(8'h32, wv[i]);
      rd_chk("wait_rb", 8'h32, wv[i]);
      check("waits", {4'h0, o_mem_waits, o_io_waits}, {4'h0, wv[i][7:4]});
    end
    io_wr(8'h32, 8'h00);
    $display("test registers done");
  endtask

  // Channel 0 transfer; the partner counts reads, writes, address steps and bus grants.
  task automatic t_xfer(input logic [7:0] mode, input logic [7:0] cnt, input logic [7:0] inc,
                        input logic [7:0] dec, input logic [7:0] grants, input logic paced);
    int r0, w0, q0, i0, d0, o0;
    logic [7:0] c0;
    io_wr(8'h31, mode);
    @(posedge i_core_clk);
    i_cnt_load <= 2'b01;
    i_cnt_value <= {8'h00, cnt};
    @(posedge i_core_clk);
    i_cnt_load <= 2'b00;
    r0 = i_partner.n_rd;
    w0 = i_partner.n_wr;
    q0 = i_partner.n_req;
    i0 = i_partner.n_inc;
    d0 = i_partner.n_dec;
    o0 = i_partner.n_iord;
    c0 = i_partner.cur;
    io_wr(8'h30, 8'h64);
    if (paced) begin
      repeat (20) @(posedge i_core_clk);
      check("unpaced", 8'(i_partner.n_rd - r0), 8'h00);
      i_ext_req_n <= 1'b0;
    end
    wait_done(6);
    i_ext_req_n <= 1'b1;
    check("reads", 8'(i_partner.n_rd - r0), cnt);
    check("writes", 8'(i_partner.n_wr - w0), cnt);
    check("wdata", i_partner.last_wdata, c0 + 8'h11 * (cnt - 8'h01));
    check("overlap", 8'(i_partner.n_ovl), 8'h00);
    check("inc", 8'(i_partner.n_inc - i0), inc);
    check("dec", 8'(i_partner.n_dec - d0), dec);
    if (!paced) check("grants", 8'(i_partner.n_req - q0), grants);
    if (paced) check("io_reads", 8'(i_partner.n_iord - o0), cnt);
    check("irq_end", {7'h00, o_irq}, 8'h01);
    rd_chk("st_end", 8'h30, 8'h35);
    $display("test transfer mode %h done", mode);
  endtask

  task automatic t_io_io();
    int r0;
    io_wr(8'h31, 8'h3c);
    @(posedge i_core_clk);
    i_cnt_load <= 2'b01;
    i_cnt_value <= 16'h0001;
    @(posedge i_core_clk);
    i_cnt_load <= 2'b00;
    r0 = i_partner.n_rd;
    i_ext_req_n <= 1'b0;
    io_wr(8'h30, 8'h64);
    repeat (30) @(posedge i_core_clk);
    check("io_io", 8'(i_partner.n_rd - r0), 8'h00);
    i_ext_req_n <= 1'b1;
    io_wr(8'h30, 8'h20);
    rd_chk("st_off", 8'h30, 8'h31);
    $display("test io to io done");
  endtask

  // Memory to a serial port on edge sense; a request held high moves one byte only.
  task automatic t_edge();
    int r0, w0;
    // edge sense for a zero-wait serial destination.
    io_wr(8'h32, 8'h08);
    io_wr(8'h31, 8'h30);
    @(posedge i_core_clk);
    i_ch0_req_sel <= 2'h1;
    i_cnt_load <= 2'b01;
    i_cnt_value <= 16'h0002;
    @(posedge i_core_clk);
    i_cnt_load <= 2'b00;
    r0 = i_partner.n_rd;
    w0 = i_partner.n_wr;
    io_wr(8'h30, 8'h64);
    repeat (10) @(posedge i_core_clk);
    check("edge_idle", 8'(i_partner.n_rd - r0), 8'h00);
    i_ser0_tx_req <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    check("edge_one", 8'(i_partner.n_rd - r0), 8'h01);
    i_ser0_tx_req <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_ser0_tx_req <= 1'b1;
    wait_done(6);
    i_ser0_tx_req <= 1'b0;
    i_ch0_req_sel <= 2'h0;
    check("edge_writes", 8'(i_partner.n_wr - w0), 8'h02);
    rd_chk("edge_end", 8'h30, 8'h35);
    $display("test edge sense done");
  endtask

  // Channel 1 from I/O into memory stepping down, two I/O wait states per read.
  task automatic t_ch1();
    int w0, d0, o0, k0, y0;
    io_wr(8'h32, 8'h23);
    @(posedge i_core_clk);
    i_ch1_req_sel <= 2'h0;
    i_cnt_load <= 2'b10;
    i_cnt_value <= 16'h0002;
    @(posedge i_core_clk);
    i_cnt_load <= 2'b00;
    w0 = i_partner.n_wr;
    d0 = i_partner.n_dec;
    o0 = i_partner.n_iord;
    k0 = i_partner.n_ch1;
    y0 = i_partner.n_rdcyc;
    io_wr(8'h30, 8'h98);
    i_ext_req_n <= 1'b0;
    wait_done(7);
    i_ext_req_n <= 1'b1;
    check("ch1_reads", 8'(i_partner.n_ch1 - k0), 8'h02);
    check("ch1_io_reads", 8'(i_partner.n_iord - o0), 8'h02);
    check("ch1_dec", 8'(i_partner.n_dec - d0), 8'h02);
    check("ch1_rd_cycles", 8'(i_partner.n_rdcyc - y0), 8'h06);
    check("ch1_writes", 8'(i_partner.n_wr - w0), 8'h02);
    check("ch1_irq", {7'h00, o_irq}, 8'h01);
    rd_chk("ch1_end", 8'h30, 8'h39);
    $display("test channel 1 done");
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    i_io_addr = 8'h00;
    i_io_wdata = 8'h00;
    i_nmi_n = 1'b1;
    i_ext_req_n = 1'b1;
    i_ser0_tx_req = 1'b0;
    i_ser1_tx_req = 1'b0;
    i_ch0_req_sel = 2'h3;
    i_ch1_req_sel = 2'h3;
    i_cnt_load = 2'b00;
    i_cnt_value = 16'h0000;
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_enable();
    t_regs();
    t_xfer(8'h00, 8'h02, 8'h04, 8'h00, 8'h02, 1'b0);
    t_xfer(8'h16, 8'h03, 8'h00, 8'h06, 8'h01, 1'b0);
    t_xfer(8'h28, 8'h02, 8'h00, 8'h00, 8'h02, 1'b0);
    i_ch0_req_sel <= 2'h0;
    t_xfer(8'h0e, 8'h02, 8'h02, 8'h00, 8'h00, 1'b1);
    t_edge();
    t_io_io();
    t_ch1();
    end_sim();
  end
endmodule
